//--- asrx_pkg.sv
// Purpose: Shared constants for the serial receive control block
// Assumes: 32-bit Avalon-MM register slave, 8-bit registers in the low lane, 9-bit character register
// Notes:   Byte addresses and field positions live here only; the debug and character register resets are literals in the control block
package asrx_pkg;
  // ==========================================================
  // Register byte addresses
  localparam logic [4:0] ASRX_OFS_LINE_FMT = 5'h00;
  localparam logic [4:0] ASRX_OFS_ENABLE = 5'h04;
  localparam logic [4:0] ASRX_OFS_ERR_IRQ = 5'h08;
  localparam logic [4:0] ASRX_OFS_STATUS = 5'h0C;
  localparam logic [4:0] ASRX_OFS_CHAR = 5'h10;
  localparam logic [4:0] ASRX_OFS_DEBUG = 5'h14;
  // ==========================================================
  // line_format_control fields
  localparam int ASRX_LF_LOOP = 7;
  localparam int ASRX_LF_ON = 6;
  localparam int ASRX_LF_FLIP = 5;
  localparam int ASRX_LF_NINE = 4;
  localparam int ASRX_LF_ROUSE = 3;
  localparam int ASRX_LF_QSTART = 2;
  localparam int ASRX_LF_PAR_ON = 1;
  localparam int ASRX_LF_PAR_ODD = 0;
  localparam logic [7:0] ASRX_LF_RESET = 8'h00;
  // ==========================================================
  // enable_control fields
  localparam int ASRX_EN_TXE_IE = 7;
  localparam int ASRX_EN_TXC_IE = 6;
  localparam int ASRX_EN_RXF_IE = 5;
  localparam int ASRX_EN_QL_IE = 4;
  localparam int ASRX_EN_TX_ON = 3;
  localparam int ASRX_EN_RX_ON = 2;
  localparam int ASRX_EN_STANDBY = 1;
  localparam logic [7:0] ASRX_EN_RESET = 8'h00;
  localparam logic [7:0] ASRX_EN_RW_MASK = 8'hFE;
  // ==========================================================
  // error_irq_control fields (also error flag positions in status)
  localparam int ASRX_ER_OVR = 3;
  localparam int ASRX_ER_NOISE = 2;
  localparam int ASRX_ER_FRAME = 1;
  localparam int ASRX_ER_PARITY = 0;
  localparam logic [3:0] ASRX_ER_RESET = 4'h0;
  // ==========================================================
  // primary_status fields
  localparam int ASRX_ST_TXE = 7;
  localparam int ASRX_ST_TXC = 6;
  localparam int ASRX_ST_RXF = 5;
  localparam int ASRX_ST_QUIET = 4;
  localparam logic [7:0] ASRX_ST_RESET = 8'hC0;
  // ==========================================================
  // Debug control field and frame lengths in bit times
  localparam int ASRX_DBG_ALLOW = 0;
  localparam logic [3:0] ASRX_FRAME_LEN_8 = 4'hA;
  localparam logic [3:0] ASRX_FRAME_LEN_9 = 4'hB;
  localparam logic [3:0] ASRX_DATA_BITS_8 = 4'h8;
  localparam logic [3:0] ASRX_DATA_BITS_9 = 4'h9;
  // ==========================================================
  // Receive framer states
  typedef enum logic [1:0] {
    ASRX_FR_IDLE = 2'b00,
    ASRX_FR_DATA = 2'b01,
    ASRX_FR_STOP = 2'b10
  } asrx_frame_e;
endpackage

//--- asrx_ctrl.sv
// Purpose: Receiver control, event flags, line format and pin steering
// Assumes: Bit sampler outside gives one strobe per bit with majority value
// Notes:   Bus accesses stall while the device is in stop mode
`timescale 1ns/100ps
`default_nettype none
module asrx_ctrl (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // Avalon-MM slave
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Bit sampler side
  input wire logic i_bit_stb,
  input wire logic i_bit_val,
  input wire logic i_bit_noisy,
  output logic o_rx_line,
  output logic o_baud_en,
  // Transmitter side
  input wire logic i_tx_level,
  input wire logic i_tx_loaded,
  input wire logic i_tx_idle,
  // Pins and port
  input wire logic i_rxd,
  input wire logic [1:0] i_port_dir,
  input wire logic i_port_out,
  output logic o_txd,
  output logic o_txd_oe,
  output logic o_rxd_oe,
  // Power and debug
  input wire logic i_stop_mode,
  input wire logic i_debug_halt,
  // Interrupt requests
  output logic o_rx_irq,
  output logic o_err_irq,
  output logic o_tx_irq,
  output logic o_wake_req
);
  import asrx_pkg::*;

  // ==========================================================
  // Registers
  logic [7:0] line_fmt;
  logic [7:0] enable_ctl;
  logic [3:0] err_ie;
  logic dbg_allow;
  logic rx_standby;
  logic tx_empty, tx_done, rx_full, quiet, ovr, noise, frame_err, par_err;
  logic [8:0] char_buf;
  logic [7:0] armed;
  logic txe_armed;
  asrx_frame_e fr_st;
  logic [3:0] bit_cnt;
  logic [8:0] shreg;
  logic fr_noisy;
  logic [3:0] ones_cnt;
  logic acc_go;

  // ==========================================================
  // Decode and control views
  logic run, mod_on, rx_act, nine, clr_ok;
  logic [3:0] frame_len, data_bits;
  logic bus_req, wr_lf, wr_en, wr_er, wr_dbg, rd_st, rd_ch, wr_ch;
  assign run = !i_stop_mode;
  assign mod_on = line_fmt[ASRX_LF_ON];
  assign nine = line_fmt[ASRX_LF_NINE];
  assign rx_act = mod_on && enable_ctl[ASRX_EN_RX_ON];
  assign frame_len = nine ? ASRX_FRAME_LEN_9 : ASRX_FRAME_LEN_8;
  assign data_bits = nine ? ASRX_DATA_BITS_9 : ASRX_DATA_BITS_8;
  assign clr_ok = !i_debug_halt || dbg_allow;
  assign bus_req = i_avs_read || i_avs_write;
  assign acc_go = bus_req && !o_avs_waitrequest;

  function automatic logic hit(input logic [4:0] ofs);
    hit = (i_avs_address == ofs);
  endfunction

  assign wr_lf = acc_go && i_avs_write && i_avs_byteenable[0] && hit(ASRX_OFS_LINE_FMT);
  assign wr_en = acc_go && i_avs_write && i_avs_byteenable[0] && hit(ASRX_OFS_ENABLE);
  assign wr_er = acc_go && i_avs_write && i_avs_byteenable[0] && hit(ASRX_OFS_ERR_IRQ);
  assign wr_dbg = acc_go && i_avs_write && i_avs_byteenable[0] && hit(ASRX_OFS_DEBUG);
  assign wr_ch = acc_go && i_avs_write && i_avs_byteenable[0] && hit(ASRX_OFS_CHAR);
  assign rd_st = acc_go && i_avs_read && hit(ASRX_OFS_STATUS);
  assign rd_ch = acc_go && i_avs_read && hit(ASRX_OFS_CHAR);

  // ==========================================================
  // Framer: keeps running in standby so wakeup can be seen
  logic strobe, done;
  logic [8:0] frame_char;
  logic frame_msb, frame_noisy, frame_bad, frame_par_bad;
  assign strobe = run && rx_act && i_bit_stb;
  assign done = strobe && (fr_st == ASRX_FR_STOP);
  assign frame_char = nine ? shreg : {1'b0, shreg[8:1]};
  assign frame_msb = shreg[8];
  assign frame_noisy = fr_noisy || i_bit_noisy;
  assign frame_bad = !i_bit_val;
  assign frame_par_bad = line_fmt[ASRX_LF_PAR_ON]
    && ((^frame_char) != line_fmt[ASRX_LF_PAR_ODD]);

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || !rx_act) begin
      fr_st <= ASRX_FR_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 9'h000;
      fr_noisy <= 1'b0;
    end else if (strobe) begin
      unique case (fr_st)
        ASRX_FR_IDLE: begin
          if (!i_bit_val) begin
            fr_st <= ASRX_FR_DATA;
            bit_cnt <= 4'h0;
            fr_noisy <= i_bit_noisy;
          end
        end
        ASRX_FR_DATA: begin
          shreg <= {i_bit_val, shreg[8:1]};
          fr_noisy <= frame_noisy;
          bit_cnt <= bit_cnt + 4'h1;
          if (bit_cnt == data_bits - 4'h1) begin
            fr_st <= ASRX_FR_STOP;
          end
        end
        ASRX_FR_STOP: begin
          fr_st <= ASRX_FR_IDLE;
        end
        default: begin
          fr_st <= ASRX_FR_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Idle line counter, saturates at one frame of ones
  logic count_ok, quiet_evt, line_idle;
  assign count_ok = line_fmt[ASRX_LF_QSTART] ? (fr_st == ASRX_FR_IDLE) : 1'b1;
  assign quiet_evt = strobe && i_bit_val && count_ok && (ones_cnt == frame_len - 4'h1);
  assign line_idle = (ones_cnt >= frame_len);

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || !rx_act) begin
      ones_cnt <= 4'h0;
    end else if (strobe) begin
      if (!i_bit_val || !count_ok) begin
        ones_cnt <= 4'h0;
      end else if (ones_cnt < frame_len) begin
        ones_cnt <= ones_cnt + 4'h1;
      end
    end
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      line_fmt <= ASRX_LF_RESET;
      err_ie <= ASRX_ER_RESET;
      dbg_allow <= 1'b0;
    end else begin
      if (wr_lf) begin
        line_fmt <= i_avs_writedata[7:0];
      end
      if (wr_er) begin
        err_ie <= i_avs_writedata[3:0];
      end
      if (wr_dbg) begin
        dbg_allow <= i_avs_writedata[ASRX_DBG_ALLOW];
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      enable_ctl <= ASRX_EN_RESET;
    end else if (wr_en) begin
      enable_ctl[ASRX_EN_TXE_IE] <= i_avs_writedata[ASRX_EN_TXE_IE];
      enable_ctl[ASRX_EN_TXC_IE] <= i_avs_writedata[ASRX_EN_TXC_IE];
      enable_ctl[ASRX_EN_RXF_IE] <= i_avs_writedata[ASRX_EN_RXF_IE];
      enable_ctl[ASRX_EN_QL_IE] <= i_avs_writedata[ASRX_EN_QL_IE];
      if (mod_on) begin
        enable_ctl[ASRX_EN_TX_ON] <= i_avs_writedata[ASRX_EN_TX_ON];
        enable_ctl[ASRX_EN_RX_ON] <= i_avs_writedata[ASRX_EN_RX_ON];
      end
    end
  end

  // Standby: wakeup wins over a software set in the same cycle
  logic addr_wake, idle_wake;
  assign addr_wake = done && rx_standby && line_fmt[ASRX_LF_ROUSE] && frame_msb;
  assign idle_wake = run && rx_act && rx_standby && !line_fmt[ASRX_LF_ROUSE]
    && line_idle;
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      rx_standby <= 1'b0;
    end else if (addr_wake || idle_wake) begin
      rx_standby <= 1'b0;
    end else if (wr_en) begin
      rx_standby <= i_avs_writedata[ASRX_EN_STANDBY];
    end
  end

  // ==========================================================
  // Receive flags and character buffer
  logic accept, take, rx_clr, rx_free;
  assign accept = done && (!rx_standby || addr_wake);
  // A character landing on the clearing read still gets the buffer
  assign rx_free = !rx_full || (rx_clr && armed[ASRX_ST_RXF]);
  assign take = accept && rx_free;
  assign rx_clr = rd_ch && clr_ok;

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      char_buf <= 9'h000;
    end else if (take) begin
      char_buf <= frame_char;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      rx_full <= 1'b0;
      ovr <= 1'b0;
      noise <= 1'b0;
      frame_err <= 1'b0;
      par_err <= 1'b0;
      quiet <= 1'b0;
    end else begin
      // Set wins over the two-step clear
      rx_full <= take || (rx_full && !(rx_clr && armed[ASRX_ST_RXF]));
      ovr <= (accept && !rx_free) || (ovr && !(rx_clr && armed[ASRX_ER_OVR]));
      noise <= (take && frame_noisy) || (noise && !(rx_clr && armed[ASRX_ER_NOISE]));
      frame_err <= (take && frame_bad)
        || (frame_err && !(rx_clr && armed[ASRX_ER_FRAME]));
      par_err <= (take && frame_par_bad)
        || (par_err && !(rx_clr && armed[ASRX_ER_PARITY]));
      quiet <= (quiet_evt && !rx_standby)
        || (quiet && !(rx_clr && armed[ASRX_ST_QUIET]));
    end
  end

  // First step of the clear: status read with flag set; kept across a halt
  logic [7:0] status;
  assign status = {tx_empty, tx_done, rx_full, quiet, ovr, noise, frame_err, par_err};
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      armed <= 8'h00;
      txe_armed <= 1'b0;
    end else if (rd_st && clr_ok) begin
      armed <= status;
      txe_armed <= tx_empty;
    end else if (rx_clr) begin
      armed <= 8'h00;
    end
  end

  // ==========================================================
  // Transmit flags
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || !mod_on) begin
      tx_empty <= 1'b1;
      tx_done <= 1'b1;
    end else if (run) begin
      tx_empty <= i_tx_loaded || (tx_empty && !(wr_ch && txe_armed && clr_ok));
      tx_done <= tx_empty && i_tx_idle;
    end
  end

  // ==========================================================
  // Pins, loopback, interrupt requests
  logic tx_line;
  assign tx_line = i_tx_level ^ line_fmt[ASRX_LF_FLIP];
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_txd <= 1'b1;
      o_txd_oe <= 1'b0;
      o_rxd_oe <= 1'b0;
      o_rx_line <= 1'b1;
      o_baud_en <= 1'b0;
    end else begin
      o_txd <= mod_on ? tx_line : i_port_out;
      o_txd_oe <= mod_on || i_port_dir[0];
      o_rxd_oe <= !mod_on && i_port_dir[1];
      o_rx_line <= line_fmt[ASRX_LF_LOOP] ? tx_line : i_rxd;
      o_baud_en <= mod_on && run;
    end
  end

  logic rx_req, err_req, tx_req;
  assign rx_req = !rx_standby && ((rx_full && enable_ctl[ASRX_EN_RXF_IE])
    || (quiet && enable_ctl[ASRX_EN_QL_IE]));
  assign err_req = |({ovr, noise, frame_err, par_err} & err_ie);
  assign tx_req = mod_on && ((tx_empty && enable_ctl[ASRX_EN_TXE_IE])
    || (tx_done && enable_ctl[ASRX_EN_TXC_IE]));
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_rx_irq <= 1'b0;
      o_err_irq <= 1'b0;
      o_tx_irq <= 1'b0;
      o_wake_req <= 1'b0;
    end else begin
      o_rx_irq <= rx_req;
      o_err_irq <= err_req;
      o_tx_irq <= tx_req;
      o_wake_req <= rx_req || err_req || tx_req;
    end
  end

  // ==========================================================
  // Avalon slave: waitrequest drops one cycle after a request
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (i_avs_address)
      ASRX_OFS_LINE_FMT: rd_mux = line_fmt;
      ASRX_OFS_ENABLE: rd_mux = (enable_ctl & ASRX_EN_RW_MASK) | {6'h00, rx_standby, 1'b0};
      ASRX_OFS_ERR_IRQ: rd_mux = {4'h0, err_ie};
      ASRX_OFS_STATUS: rd_mux = status;
      ASRX_OFS_CHAR: rd_mux = char_buf[7:0];
      ASRX_OFS_DEBUG: rd_mux = {7'h00, dbg_allow};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0000_0000;
    end else if (bus_req && o_avs_waitrequest && run) begin
      o_avs_waitrequest <= 1'b0;
      o_avs_readdata <= (hit(ASRX_OFS_CHAR)) ? {23'h000000, char_buf} : {24'h000000, rd_mux};
    end else begin
      o_avs_waitrequest <= 1'b1;
    end
  end

  // ==========================================================
  // Checks
  standby_mute_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    rx_standby |=> !o_rx_irq) else $error("rx irq while in standby");
  addr_wake_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    addr_wake |=> !rx_standby && rx_full) else $error("address mark not handled");
  idle_wake_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    idle_wake && !quiet |=> !rx_standby && !quiet) else $error("idle wake wrong");
  overrun_keep_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    accept && !rx_free |=> ovr && $stable(char_buf)) else $error("overrun lost old");
  frame_same_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    $rose(frame_err) |-> rx_full && $past(take)) else $error("framing without full");
  enable_lock_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    !mod_on |=> $stable(enable_ctl[ASRX_EN_RX_ON])) else $error("rx_on changed");
  pin_own_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    mod_on |=> o_txd_oe && !o_rxd_oe) else $error("pins not owned");
  tx_off_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    !mod_on |=> tx_empty && tx_done && !o_tx_irq) else $error("tx flags wrong");
  err_or_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    err_req |=> o_err_irq && o_wake_req) else $error("error irq missing");
  halt_keep_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    i_debug_halt && !dbg_allow && rx_full && !take |=> rx_full)
    else $error("flag cleared in halt");
endmodule // asrx_ctrl
`default_nettype wire

//--- asrx_node.sv
// Purpose: Remote serial node as seen through the bit sampler strobes
// Assumes: One bit strobe every four clocks while a frame is on the line
// Notes:   Value line flips after each strobe, so stale levels never help
`timescale 1ns/100ps
`default_nettype none
module asrx_node (
  // Clock
  input wire logic i_mclk,
  // Sampler side
  output logic o_bit_stb,
  output logic o_bit_val,
  output logic o_bit_noisy
);
  initial begin
    o_bit_stb = 1'b0;
    o_bit_val = 1'b0;
    o_bit_noisy = 1'b0;
  end
  // ==========================================================
  // One bit time
  task automatic send_bit(input logic v, input logic nz);
    @(posedge i_mclk);
    o_bit_val <= v;
    o_bit_noisy <= nz;
    o_bit_stb <= 1'b1;
    @(posedge i_mclk);
    o_bit_stb <= 1'b0;
    o_bit_noisy <= 1'b0;
    o_bit_val <= ~v;
    repeat (2) @(posedge i_mclk);
  endtask
  // ==========================================================
  // Start, data LSB first, stop
  task automatic frame(input logic [8:0] d, input int nb, input logic stop,
                       input logic nz);
    send_bit(1'b0, 1'b0);
    for (int i = 0; i < nb; i++) begin
      send_bit(d[i], nz && (i == 1));
    end
    send_bit(stop, 1'b0);
  endtask
  task automatic ones(input int n);
    for (int i = 0; i < n; i++) begin
      send_bit(1'b1, 1'b0);
    end
  endtask
endmodule // asrx_node
`default_nettype wire

//--- tb_top.sv
// Purpose: Self-checking bench for the serial receive control block
// Assumes: Bus answers one cycle after the take edge, flags one after stop
// Notes:   Transmitter inputs are held quiet except where a test drives them
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import asrx_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] addr = 5'h00;
  logic rd_s = 1'b0;
  logic wr_s = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic wreq, stb, val, noisy, rx_line, baud_en, txd, txd_oe, rxd_oe;
  logic rx_irq, err_irq, tx_irq, wake;
  logic tx_level = 1'b1;
  logic stop_m = 1'b0;
  logic [1:0] port_dir = 2'b10;
  logic rxd_pin = 1'b1;
  logic dbg_halt = 1'b0;
  logic port_out = 1'b0;
  logic [8:0] v;
  int n_errors = 0;
  int check_count = 0;
  always #2.5 clk = ~clk;
  asrx_node node (.i_mclk(clk), .o_bit_stb(stb), .o_bit_val(val), .o_bit_noisy(noisy));
  asrx_ctrl i_asrx_ctrl (
    .i_mclk(clk), .i_sys_rst(rst), .i_avs_address(addr), .i_avs_read(rd_s),
    .i_avs_write(wr_s), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_bit_stb(stb),
    .i_bit_val(val), .i_bit_noisy(noisy), .o_rx_line(rx_line), .o_baud_en(baud_en),
    .i_tx_level(tx_level), .i_tx_loaded(1'b0), .i_tx_idle(1'b1), .i_rxd(rxd_pin),
    .i_port_dir(port_dir), .i_port_out(port_out), .o_txd(txd), .o_txd_oe(txd_oe),
    .o_rxd_oe(rxd_oe), .i_stop_mode(stop_m), .i_debug_halt(dbg_halt),
    .o_rx_irq(rx_irq), .o_err_irq(err_irq), .o_tx_irq(tx_irq), .o_wake_req(wake));
  // ==========================================================
  // Compare and report
  task automatic chk_reg(input logic [8:0] got, input logic [8:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t reg got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t level got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ==========================================================
  // Bus master: hold until waitrequest seen low at an edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= {24'h0, d};
    if (w) wr_s <= 1'b1;
    else rd_s <= 1'b1;
    // Only the watchdog ends a wait that never sees an answer
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    v = rdata[8:0];
    wr_s <= 1'b0;
    rd_s <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rchk(input logic [4:0] a, input logic [8:0] exp);
    bus(1'b0, a, 8'h00);
    chk_reg(v, exp);
  endtask
  task automatic st_bit(input int b, input logic exp);
    repeat (2) @(posedge clk);
    bus(1'b0, ASRX_OFS_STATUS, 8'h00);
    chk_bit(v[b], exp);
  endtask
  task automatic clr;
    bus(1'b0, ASRX_OFS_STATUS, 8'h00);
    bus(1'b0, ASRX_OFS_CHAR, 8'h00);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset_gate;
    rchk(ASRX_OFS_LINE_FMT, 9'h000);
    rchk(ASRX_OFS_STATUS, 9'h0C0);
    wr(ASRX_OFS_ENABLE, 8'h8C);
    rchk(ASRX_OFS_ENABLE, 9'h080);
    chk_bit(tx_irq, 1'b0);
    rchk(5'h18, 9'h000);
    wr(ASRX_OFS_LINE_FMT, 8'h40);
    repeat (2) @(posedge clk);
    chk_bit(tx_irq, 1'b1);
    chk_bit(wake, 1'b1);
    wr(ASRX_OFS_ENABLE, 8'h2C);
    rchk(ASRX_OFS_ENABLE, 9'h02C);
    repeat (3) @(posedge clk);
    chk_bit(txd_oe, 1'b1);
    chk_bit(rxd_oe, 1'b0);
    chk_bit(baud_en, 1'b1);
    $display("test reset_gate done");
  endtask
  task automatic t_rx_full;
    node.frame(9'h05A, 8, 1'b1, 1'b0);
    st_bit(ASRX_ST_RXF, 1'b1);
    chk_bit(rx_irq, 1'b1);
    rchk(ASRX_OFS_CHAR, 9'h05A);
    repeat (3) @(posedge clk);
    chk_bit(rx_irq, 1'b0);
    $display("test rx_full done");
  endtask
  task automatic t_errors;
    wr(ASRX_OFS_ERR_IRQ, 8'h02);
    node.frame(9'h033, 8, 1'b0, 1'b1);
    repeat (2) @(posedge clk);
    bus(1'b0, ASRX_OFS_STATUS, 8'h00);
    chk_reg({3'b000, v[5:0]}, 9'h026);
    chk_bit(err_irq, 1'b1);
    wr(ASRX_OFS_ERR_IRQ, 8'h04);
    repeat (2) @(posedge clk);
    chk_bit(err_irq, 1'b1);
    wr(ASRX_OFS_ERR_IRQ, 8'h00);
    repeat (2) @(posedge clk);
    chk_bit(err_irq, 1'b0);
    clr;
    node.frame(9'h011, 8, 1'b1, 1'b0);
    node.frame(9'h022, 8, 1'b1, 1'b0);
    st_bit(ASRX_ER_OVR, 1'b1);
    rchk(ASRX_OFS_CHAR, 9'h011);
    $display("test errors done");
  endtask
  task automatic t_format;
    // Even then odd parity in the character MSB
    wr(ASRX_OFS_LINE_FMT, 8'h42);
    clr;
    node.frame(9'h081, 8, 1'b1, 1'b0);
    st_bit(ASRX_ER_PARITY, 1'b0);
    clr;
    node.frame(9'h001, 8, 1'b1, 1'b0);
    st_bit(ASRX_ER_PARITY, 1'b1);
    wr(ASRX_OFS_LINE_FMT, 8'h43);
    clr;
    node.frame(9'h001, 8, 1'b1, 1'b0);
    st_bit(ASRX_ER_PARITY, 1'b0);
    wr(ASRX_OFS_LINE_FMT, 8'h50);
    clr;
    node.frame(9'h1A5, 9, 1'b1, 1'b0);
    rchk(ASRX_OFS_CHAR, 9'h1A5);
    $display("test format done");
  endtask
  task automatic t_wake;
    wr(ASRX_OFS_LINE_FMT, 8'h48);
    clr;
    wr(ASRX_OFS_ENABLE, 8'h2E);
    node.frame(9'h005, 8, 1'b1, 1'b0);
    st_bit(ASRX_ST_RXF, 1'b0);
    chk_bit(rx_irq, 1'b0);
    node.frame(9'h085, 8, 1'b1, 1'b0);
    st_bit(ASRX_ST_RXF, 1'b1);
    rchk(ASRX_OFS_ENABLE, 9'h02C);
    chk_bit(rx_irq, 1'b1);
    wr(ASRX_OFS_ENABLE, 8'h2E);
    repeat (2) @(posedge clk);
    chk_bit(rx_irq, 1'b0);
    wr(ASRX_OFS_ENABLE, 8'h2C);
    // Idle line wakeup, count from the start bit
    wr(ASRX_OFS_LINE_FMT, 8'h40);
    clr;
    node.frame(9'h0FF, 8, 1'b1, 1'b0);
    st_bit(ASRX_ST_QUIET, 1'b0);
    node.ones(1);
    st_bit(ASRX_ST_QUIET, 1'b1);
    wr(ASRX_OFS_ENABLE, 8'h2E);
    repeat (3) @(posedge clk);
    rchk(ASRX_OFS_ENABLE, 9'h02C);
    node.frame(9'h000, 8, 1'b1, 1'b0);
    clr;
    wr(ASRX_OFS_ENABLE, 8'h2E);
    rchk(ASRX_OFS_ENABLE, 9'h02E);
    node.ones(10);
    rchk(ASRX_OFS_ENABLE, 9'h02C);
    bus(1'b0, ASRX_OFS_STATUS, 8'h00);
    chk_reg({7'h00, v[ASRX_ST_RXF], v[ASRX_ST_QUIET]}, 9'h000);
    $display("test wake done");
  endtask
  task automatic t_halt;
    node.frame(9'h03C, 8, 1'b1, 1'b0);
    st_bit(ASRX_ST_RXF, 1'b1);
    dbg_halt <= 1'b1;
    rchk(ASRX_OFS_CHAR, 9'h03C);
    st_bit(ASRX_ST_RXF, 1'b1);
    dbg_halt <= 1'b0;
    rchk(ASRX_OFS_CHAR, 9'h03C);
    st_bit(ASRX_ST_RXF, 1'b0);
    wr(ASRX_OFS_DEBUG, 8'h01);
    node.frame(9'h0C3, 8, 1'b1, 1'b0);
    dbg_halt <= 1'b1;
    clr;
    st_bit(ASRX_ST_RXF, 1'b0);
    dbg_halt <= 1'b0;
    wr(ASRX_OFS_DEBUG, 8'h00);
    $display("test halt done");
  endtask
  task automatic t_pins;
    wr(ASRX_OFS_LINE_FMT, 8'h60);
    repeat (3) @(posedge clk);
    chk_bit(txd, 1'b0);
    tx_level <= 1'b0;
    rxd_pin <= 1'b0;
    repeat (3) @(posedge clk);
    chk_bit(txd, 1'b1);
    chk_bit(rx_line, 1'b0);
    rxd_pin <= 1'b1;
    wr(ASRX_OFS_LINE_FMT, 8'hC0);
    repeat (3) @(posedge clk);
    chk_bit(rx_line, 1'b0);
    stop_m <= 1'b1;
    repeat (3) @(posedge clk);
    chk_bit(baud_en, 1'b0);
    stop_m <= 1'b0;
    rchk(ASRX_OFS_LINE_FMT, 9'h0C0);
    // Mid-run reset: module off hands the pins back to the port
    rst <= 1'b1;
    tx_level <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rchk(ASRX_OFS_LINE_FMT, 9'h000);
    chk_bit(txd, 1'b0);
    chk_bit(txd_oe, 1'b0);
    chk_bit(rxd_oe, 1'b1);
    $display("test pins done");
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset_gate();
    t_rx_full();
    t_errors();
    t_format();
    t_wake();
    t_halt();
    t_pins();
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
